// ---- design/eeprom_access_control.sv ----
// EEPROM access control: registers, write sequencing, stall and ready irq
//
// Overview of operation
// - Program data register byte at addressed location
// - Read places addressed byte into data register
// - Decode data offset, or offset minus 0x20
// - Mode field selects erase+write, erase, write
// - Atomic takes about 3.4ms, others 1.8ms
// - Mode field locked while write strobe set
// - Reset clears mode unless programming busy
// - Ready irq level while strobe clear, enabled
// - No ready irq during programming or self-program
// - Strobe within four cycles of enable starts
// - Strobe ignored without master enable
// - Master enable self-clears after four cycles
// - No EEPROM programming starts while flash is written
// - Strobe self-clears when programming time elapses
// - Write start stalls CPU two cycles
// - Read completes within the strobing instruction
// - Every read stalls CPU four cycles
// - Busy refuses reads and address changes
// - Programming timed in RC oscillator cycles
// - Address selects one of 2048 bytes
`timescale 1ns/1ps
`default_nettype none
module eeprom_access_control #(
    parameter int ADDR_W        = 11,
    parameter int DEPTH         = 2048,
    parameter int FULL_RC_COUNT = eeprom_access_pkg::RC_CYCLES_FULL,
    parameter int HALF_RC_COUNT = eeprom_access_pkg::RC_CYCLES_HALF
) (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_reset,
    input  wire eeprom_access_pkg::cpu_req_type i_req,
    input  wire logic                          i_global_irq_en,
    input  wire logic                          i_self_prog_active,
    input  wire logic                          i_rc_osc,
    output logic [7:0]                         o_rdata,
    output logic                               o_stall,
    output logic                               o_ready_irq,
    output logic                               o_busy
);
    import eeprom_access_pkg::*;

    // ************************************************************
    // Storage and registers
    // ************************************************************
    logic [7:0]        mem [DEPTH];
    logic [7:0]        eeprom_data_reg_r;
    logic [ADDR_W-1:0] eeprom_addr_reg_r;
    logic [1:0]        prog_mode_field_r;
    logic              ready_irq_enable_r;
    logic              master_write_enable_r;
    // Power-up value only: reset must not cut a write short
    logic              write_strobe_r = 1'b0;
    logic [2:0]        master_cnt_r;
    logic [2:0]        stall_cnt_r;
    logic [15:0]       rc_cnt_r;
    logic [1:0]        op_mode_r;
    logic              rc_meta_r;
    logic              rc_sync_r;
    logic              rc_prev_r;
    logic              self_meta_r;
    logic              self_sync_r;
    logic [7:0]        rdata_r;

    logic              hit_ctrl;
    logic              hit_data;
    logic              hit_alo;
    logic              hit_ahi;
    logic [7:0]        eff_addr;
    logic              wr_ctrl;
    logic              start_prog;
    logic              start_read;
    logic              rc_tick;
    logic              prog_done;
    logic [15:0]       op_len;

    // ************************************************************
    // Address decode
    // ************************************************************
    // I/O instructions reach the same register 0x20 lower
    assign eff_addr = i_req.io_space ? i_req.addr + IO_SPACE_OFFSET
                                     : i_req.addr;
    assign hit_ctrl = (eff_addr == CTRL_OFFSET);
    assign hit_data = (eff_addr == DATA_OFFSET);
    assign hit_alo  = (eff_addr == ADDR_LO_OFFSET);
    assign hit_ahi  = (eff_addr == ADDR_HI_OFFSET);
    assign wr_ctrl  = i_req.wr && hit_ctrl;

    // ************************************************************
    // Synchronisers
    // ************************************************************
    // Oscillator and flash status come from outside this clock
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rc_meta_r   <= 1'b0;
            rc_sync_r   <= 1'b0;
            rc_prev_r   <= 1'b0;
            self_meta_r <= 1'b0;
            self_sync_r <= 1'b0;
        end else begin
            rc_meta_r   <= i_rc_osc;
            rc_sync_r   <= rc_meta_r;
            rc_prev_r   <= rc_sync_r;
            self_meta_r <= i_self_prog_active;
            self_sync_r <= self_meta_r;
        end
    end
    assign rc_tick = rc_sync_r && !rc_prev_r;

    // ************************************************************
    // Write sequencing
    // ************************************************************
    // Flash programming blocks an EEPROM start outright
    assign start_prog = wr_ctrl && i_req.wdata[WRITE_STROBE_BIT]
                        && master_write_enable_r && !write_strobe_r
                        && !self_sync_r
                        && (prog_mode_field_r != 2'h3);
    assign start_read = wr_ctrl && i_req.wdata[READ_STROBE_BIT]
                        && !write_strobe_r;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            master_write_enable_r <= 1'b0;
            master_cnt_r          <= 3'h0;
        end else if (wr_ctrl && i_req.wdata[MASTER_ENABLE_BIT]
                     && !i_req.wdata[WRITE_STROBE_BIT]) begin
            master_write_enable_r <= 1'b1;
            master_cnt_r          <= 3'(MASTER_WINDOW_CYCLES);
        end else if (master_cnt_r == 3'h1 || start_prog) begin
            master_write_enable_r <= 1'b0;
            master_cnt_r          <= 3'h0;
        end else if (master_cnt_r != 3'h0) begin
            master_cnt_r          <= master_cnt_r - 3'h1;
        end
    end

    // Atomic mode takes both the erase and write phases
    assign op_len = (op_mode_r == MODE_ERASE_WRITE)
                    ? 16'(FULL_RC_COUNT) : 16'(HALF_RC_COUNT);
    assign prog_done = write_strobe_r && rc_tick
                       && (rc_cnt_r + 16'h1 >= op_len);

    // Strobe survives reset so a started write always finishes
    always_ff @(posedge i_core_clk) begin
        if (start_prog) begin
            write_strobe_r <= 1'b1;
            op_mode_r      <= prog_mode_field_r;
            rc_cnt_r       <= 16'h0;
        end else if (prog_done) begin
            write_strobe_r <= 1'b0;
            rc_cnt_r       <= 16'h0;
        end else if (write_strobe_r && rc_tick) begin
            rc_cnt_r       <= rc_cnt_r + 16'h1;
        end
    end

    // ************************************************************
    // Array access
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (prog_done) begin
            unique case (op_mode_r)
                MODE_ERASE_WRITE: mem[eeprom_addr_reg_r] <= eeprom_data_reg_r;
                MODE_ERASE_ONLY:  mem[eeprom_addr_reg_r] <= 8'hFF;
                MODE_WRITE_ONLY:  mem[eeprom_addr_reg_r] <=
                    mem[eeprom_addr_reg_r] & eeprom_data_reg_r;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Data, address and control registers
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            eeprom_data_reg_r <= DATA_RESET;
        end else if (start_read) begin
            eeprom_data_reg_r <= mem[eeprom_addr_reg_r];
        end else if (i_req.wr && hit_data) begin
            eeprom_data_reg_r <= i_req.wdata;
        end
    end

    // Left unreset: contents are undefined until software loads it
    always_ff @(posedge i_core_clk) begin
        if (!write_strobe_r && i_req.wr && hit_alo) begin
            eeprom_addr_reg_r[7:0] <= i_req.wdata;
        end else if (!write_strobe_r && i_req.wr && hit_ahi) begin
            eeprom_addr_reg_r[ADDR_W-1:8] <=
                i_req.wdata[ADDR_W-9:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ready_irq_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable_r <= i_req.wdata[READY_IRQ_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset && !write_strobe_r) begin
            prog_mode_field_r <= MODE_RESET;
        end else if (!i_reset && wr_ctrl && !write_strobe_r) begin
            prog_mode_field_r <=
                i_req.wdata[PROG_MODE_LSB+1:PROG_MODE_LSB];
        end
    end

    // ************************************************************
    // CPU stall
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            stall_cnt_r <= 3'h0;
        end else if (start_read) begin
            stall_cnt_r <= 3'(READ_STALL_CYCLES);
        end else if (start_prog) begin
            stall_cnt_r <= 3'(WRITE_STALL_CYCLES);
        end else if (stall_cnt_r != 3'h0) begin
            stall_cnt_r <= stall_cnt_r - 3'h1;
        end
    end
    assign o_stall = (stall_cnt_r != 3'h0);

    // ************************************************************
    // Read data and status
    // ************************************************************
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rdata_r <= 8'h00;
        end else if (i_req.rd && hit_ctrl) begin
            rdata_r <= {2'h0, prog_mode_field_r, ready_irq_enable_r,
                        master_write_enable_r, write_strobe_r,
                        1'b0};
        end else if (i_req.rd && hit_data) begin
            rdata_r <= eeprom_data_reg_r;
        end else if (i_req.rd && hit_alo) begin
            rdata_r <= eeprom_addr_reg_r[7:0];
        end else if (i_req.rd && hit_ahi) begin
            rdata_r <= {{(16-ADDR_W){1'b0}}, eeprom_addr_reg_r[ADDR_W-1:8]};
        end else if (i_req.rd) begin
            rdata_r <= 8'h00;
        end
    end
    assign o_rdata = rdata_r;
    assign o_busy  = write_strobe_r;

    assign o_ready_irq = ready_irq_enable_r && i_global_irq_en
                         && !write_strobe_r
                         && !self_sync_r;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_master_timeout:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        $rose(master_write_enable_r) |-> ##[1:4] !master_write_enable_r)
        else $error("master enable did not time out");
    chk_no_enable_start:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (wr_ctrl && !master_write_enable_r && !write_strobe_r)
        |=> !write_strobe_r)
        else $error("write started without master enable");
    chk_write_stall:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        start_prog |=> o_stall [*2] ##1 !o_stall)
        else $error("write stall not two cycles");
    chk_read_stall:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        start_read |=> o_stall [*4] ##1 !o_stall)
        else $error("read stall not four cycles");
    chk_read_data:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        start_read |=> eeprom_data_reg_r == $past(mem[eeprom_addr_reg_r]))
        else $error("read data wrong");
    chk_mode_locked:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        write_strobe_r |=> $stable(prog_mode_field_r))
        else $error("mode changed while busy");
    chk_addr_locked:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        write_strobe_r |=> $stable(eeprom_addr_reg_r))
        else $error("address changed while busy");
    chk_irq_busy:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (write_strobe_r || self_sync_r) |-> !o_ready_irq)
        else $error("ready irq while busy");
    chk_irq_level:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (ready_irq_enable_r && i_global_irq_en && !write_strobe_r
         && !self_sync_r) |-> o_ready_irq)
        else $error("ready irq missing");
    chk_mode_reset:
        assert property (@(posedge i_core_clk)
        (i_reset && !write_strobe_r) |=> prog_mode_field_r == MODE_RESET)
        else $error("mode field not cleared by reset");
    chk_strobe_kept:
        assert property (@(posedge i_core_clk)
        (i_reset && write_strobe_r && !prog_done) |=> write_strobe_r)
        else $error("reset cut a write short");
    chk_done_clears:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        prog_done |=> !write_strobe_r)
        else $error("write strobe not cleared at end");
    chk_reserved_mode:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (wr_ctrl && prog_mode_field_r == 2'h3 && !write_strobe_r)
        |=> !write_strobe_r)
        else $error("reserved mode started a write");
    chk_flash_blocks:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (self_sync_r && !write_strobe_r) |=> !write_strobe_r)
        else $error("write started during flash programming");
    chk_ctrl_readback:
        assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        (i_req.rd && hit_ctrl) |=> (o_rdata[7:6] == 2'h0 && !o_rdata[0]))
        else $error("control readback reserved bits set");

    cov_write: cover property (@(posedge i_core_clk) start_prog);
    cov_done:  cover property (@(posedge i_core_clk) prog_done);
    cov_read:  cover property (@(posedge i_core_clk) start_read);
    cov_irq:   cover property (@(posedge i_core_clk) $rose(o_ready_irq));
    cov_reset_busy: cover property (@(posedge i_core_clk)
        i_reset && write_strobe_r);
endmodule : eeprom_access_control
`default_nettype wire

// ---- design/eeprom_access_pkg.sv ----
// Package: offsets, fields, reset values and timing of the EEPROM access block
package eeprom_access_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] IO_SPACE_OFFSET  = 8'h20;
    localparam logic [7:0] CTRL_OFFSET      = 8'h3F;
    localparam logic [7:0] DATA_OFFSET      = 8'h40;
    localparam logic [7:0] ADDR_LO_OFFSET   = 8'h41;
    localparam logic [7:0] ADDR_HI_OFFSET   = 8'h42;
    localparam logic [7:0] DATA_RESET       = 8'h00;

    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int READ_STROBE_BIT   = 0;
    localparam int WRITE_STROBE_BIT  = 1;
    localparam int MASTER_ENABLE_BIT = 2;
    localparam int READY_IRQ_BIT     = 3;
    localparam int PROG_MODE_LSB     = 4;

    localparam logic [1:0] MODE_ERASE_WRITE = 2'h0;
    localparam logic [1:0] MODE_ERASE_ONLY  = 2'h1;
    localparam logic [1:0] MODE_WRITE_ONLY  = 2'h2;
    localparam logic [1:0] MODE_RESET       = 2'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int MASTER_WINDOW_CYCLES = 4;
    localparam int WRITE_STALL_CYCLES   = 2;
    localparam int READ_STALL_CYCLES    = 4;
    localparam int RC_CYCLES_FULL       = 26368;
    localparam int RC_CYCLES_HALF       = 14336;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       io_space;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;
endpackage : eeprom_access_pkg

// ---- test/cpu_partner.sv ----
// CPU-side partner: register bus cycles, flash busy flag and RC oscillator
`timescale 1ns/1ps
`default_nettype none
module cpu_partner (
    input  wire logic                           i_core_clk,
    input  wire logic [7:0]                     i_rdata,
    input  wire logic                           i_stall,
    input  wire logic                           i_busy,
    output var  eeprom_access_pkg::cpu_req_type o_req,
    output var  logic                           o_global_irq_en,
    output var  logic                           o_self_prog_active,
    output var  logic                           o_rc_osc
);
    import eeprom_access_pkg::*;
    // ************************************************************
    // Bus cycles
    // ************************************************************
    initial begin
        o_req = '0;
        o_global_irq_en = 1'b0;
        o_self_prog_active = 1'b0;
        o_rc_osc = 1'b0;
        // Free running, phase unrelated to the core clock
        forever #65 o_rc_osc = ~o_rc_osc;
    end

    // Halted core issues nothing while stall is high
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input logic io,
                       output logic [7:0] q);
        @(posedge i_core_clk);
        while (i_stall === 1'b1) @(posedge i_core_clk);
        o_req <= '{wr: w, rd: ~w, io_space: io, addr: a, wdata: d};
        @(posedge i_core_clk);
        o_req <= '0;
        if (!w) begin
            @(posedge i_core_clk);
            q = i_rdata;
        end
    endtask : bus

    task automatic wait_idle(output int n);
        n = 0;
        while (i_busy === 1'b1 && n < 4000) begin
            @(posedge i_core_clk);
            n++;
        end
    endtask : wait_idle

    task automatic program_byte(input logic [10:0] a, input logic [7:0] d,
                                input logic [1:0] m);
        logic [7:0] q;
        logic       g;
        int         n;
        wait_idle(n);
        while (o_self_prog_active === 1'b1) @(posedge i_core_clk);
        g = o_global_irq_en;
        o_global_irq_en <= 1'b0;
        bus(1'b1, ADDR_LO_OFFSET, a[7:0], 1'b0, q);
        bus(1'b1, ADDR_HI_OFFSET, {5'h00, a[10:8]}, 1'b0, q);
        bus(1'b1, DATA_OFFSET, d, 1'b0, q);
        bus(1'b1, CTRL_OFFSET, {2'h0, m, 4'h4}, 1'b0, q);
        bus(1'b1, CTRL_OFFSET, {2'h0, m, 4'h2}, 1'b0, q);
        o_global_irq_en <= g;
    endtask : program_byte
endmodule : cpu_partner
`default_nettype wire

// ---- test/test_eeprom_access_control.sv ----
// Self-checking bench for the EEPROM access block
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_access_control;
    import eeprom_access_pkg::*;
    logic        i_core_clk;
    logic        i_reset;
    cpu_req_type req;
    logic        gie;
    logic        spa;
    logic        rc;
    logic [7:0]  rdata;
    logic        stall;
    logic        irq;
    logic        busy;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    // Short counts keep the run brief; expectations only compare them
    eeprom_access_control #(.FULL_RC_COUNT(8), .HALF_RC_COUNT(4)) dut (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_req(req),
        .i_global_irq_en(gie), .i_self_prog_active(spa), .i_rc_osc(rc),
        .o_rdata(rdata), .o_stall(stall), .o_ready_irq(irq), .o_busy(busy));
    cpu_partner cpu (
        .i_core_clk(i_core_clk), .i_rdata(rdata), .i_stall(stall),
        .i_busy(busy), .o_req(req), .o_global_irq_en(gie),
        .o_self_prog_active(spa), .o_rc_osc(rc));

    // ************************************************************
    // Checks and scenarios
    // ************************************************************
    task automatic end_of_test();
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic count_stall(output logic [7:0] n);
        n = 8'h00;
        repeat (8) begin
            @(posedge i_core_clk);
            if (stall === 1'b1) n++;
        end
    endtask : count_stall

    task automatic read_cell(input logic [10:0] a, output logic [7:0] q);
        logic [7:0] n;
        cpu.bus(1'b1, ADDR_LO_OFFSET, a[7:0], 1'b0, q);
        cpu.bus(1'b1, ADDR_HI_OFFSET, {5'h00, a[10:8]}, 1'b0, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h01, 1'b0, q);
        count_stall(n);
        chk("read_stall", 8'h04, n);
        cpu.bus(1'b0, DATA_OFFSET, 8'h00, 1'b0, q);
    endtask : read_cell

    task automatic t_regs();
        logic [7:0] q;
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("ctrl_reset", 8'h00, q);
        cpu.bus(1'b0, DATA_OFFSET - IO_SPACE_OFFSET, 8'h00, 1'b1, q);
        chk("data_reset_io", DATA_RESET, q);
        cpu.bus(1'b1, CTRL_OFFSET - IO_SPACE_OFFSET, 8'hC8, 1'b1, q);
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("ctrl_upper_bits", 8'h08, q);
        cpu.o_global_irq_en <= 1'b1;
        @(posedge i_core_clk);
        chk("irq_idle", 8'h01, {7'h00, irq});
        cpu.o_self_prog_active <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        chk("irq_flash", 8'h00, {7'h00, irq});
        cpu.o_self_prog_active <= 1'b0;
        cpu.bus(1'b1, CTRL_OFFSET, 8'h00, 1'b0, q);
        @(posedge i_core_clk);
        chk("irq_masked", 8'h00, {7'h00, irq});
    endtask : t_regs

    task automatic t_modes();
        logic [7:0] d[3] = '{8'hA5, 8'h00, 8'h3C};
        logic [7:0] e[3] = '{8'hA5, 8'hFF, 8'h3C};
        int         t[3];
        logic [7:0] q;
        for (int m = 0; m < 3; m++) begin
            cpu.program_byte(11'h7FF, d[m], m[1:0]);
            count_stall(q);
            chk("write_stall", 8'h02, q);
            cpu.wait_idle(t[m]);
            cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
            chk("ctrl_done", {2'h0, m[1:0], 4'h0}, q);
            read_cell(11'h7FF, q);
            chk("cell", e[m], q);
        end
        chk("full_longer", 8'h01, {7'h00, t[0] > t[1] && t[0] > t[2]});
    endtask : t_modes

    task automatic try_start(input string nm, input logic [7:0] c);
        logic [7:0] q;
        cpu.bus(1'b1, CTRL_OFFSET, c | 8'h04, 1'b0, q);
        cpu.bus(1'b1, CTRL_OFFSET, c | 8'h02, 1'b0, q);
        repeat (2) @(posedge i_core_clk);
        chk(nm, 8'h00, {7'h00, busy});
    endtask : try_start

    task automatic t_refuse();
        logic [7:0] q;
        int         n;
        cpu.bus(1'b1, CTRL_OFFSET, 8'h02, 1'b0, q);
        repeat (2) @(posedge i_core_clk);
        chk("no_master", 8'h00, {7'h00, busy});
        cpu.bus(1'b1, CTRL_OFFSET, 8'h04, 1'b0, q);
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("master_set", 8'h04, q);
        repeat (4) @(posedge i_core_clk);
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("master_gone", 8'h00, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h02, 1'b0, q);
        repeat (2) @(posedge i_core_clk);
        chk("late_strobe", 8'h00, {7'h00, busy});
        try_start("mode_reserved", 8'h30);
        cpu.o_self_prog_active <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        try_start("flash_busy", 8'h00);
        cpu.o_self_prog_active <= 1'b0;
        cpu.program_byte(11'h001, 8'h5A, MODE_ERASE_WRITE);
        cpu.bus(1'b1, ADDR_LO_OFFSET, 8'h02, 1'b0, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h38, 1'b0, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h09, 1'b0, q);
        cpu.o_global_irq_en <= 1'b1;
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("mode_locked", 8'h0A, q);
        chk("irq_busy", 8'h00, {7'h00, irq});
        cpu.wait_idle(n);
        @(posedge i_core_clk);
        chk("irq_ready", 8'h01, {7'h00, irq});
        cpu.bus(1'b1, DATA_OFFSET, 8'h00, 1'b0, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h01, 1'b0, q);
        cpu.bus(1'b0, DATA_OFFSET, 8'h00, 1'b0, q);
        chk("addr_locked", 8'h5A, q);
        cpu.bus(1'b1, CTRL_OFFSET, 8'h00, 1'b0, q);
    endtask : t_refuse

    task automatic t_reset_busy();
        logic [7:0] q;
        int         n;
        cpu.program_byte(11'h010, 8'h00, MODE_ERASE_ONLY);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'b0;
        cpu.bus(1'b0, CTRL_OFFSET, 8'h00, 1'b0, q);
        chk("mode_kept", 8'h12, q);
        cpu.wait_idle(n);
        read_cell(11'h010, q);
        chk("erase_survives", 8'hFF, q);
    endtask : t_reset_busy

    initial begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    initial begin
        i_reset = 1'b1;
        repeat (10) @(posedge i_core_clk);
        i_reset <= 1'b0;
        t_regs();
        t_modes();
        t_refuse();
        t_reset_busy();
        end_of_test();
    end
endmodule : test_eeprom_access_control
`default_nettype wire
